// ### hdl/tcc_pkg.sv
// shared constants for the timer capture/compare/pwm channel block
package tcc_pkg;
  localparam int TCC_NCH = 6;
  localparam int TCC_CW = 16;
  // register word indices (byte address = 4 * index)
  localparam logic [7:0] TCC_IDX_GCTRL = 8'h00;
  localparam logic [7:0] TCC_IDX_MOD = 8'h01;
  localparam logic [7:0] TCC_IDX_COUNT = 8'h02;
  localparam logic [7:0] TCC_IDX_CH_BASE = 8'h04;
  localparam logic [7:0] TCC_IDX_VAL_BASE = 8'h0C;
  localparam logic [7:0] TCC_IDX_PIN = 8'h14;
  // channel control field positions
  localparam int TCC_B_MAX = 0;
  localparam int TCC_B_TOV = 1;
  localparam int TCC_B_ELA = 2;
  localparam int TCC_B_ELB = 3;
  localparam int TCC_B_MSA = 4;
  localparam int TCC_B_MSB = 5;
  localparam int TCC_B_IE = 6;
  localparam int TCC_B_FLAG = 7;
  // global control field positions
  localparam int TCC_B_PS = 0;
  localparam int TCC_B_STOP = 5;
  localparam int TCC_B_RST = 4;
  localparam logic [7:0] TCC_CTRL_RST = 8'h00;
  localparam logic [7:0] TCC_GCTRL_RST = 8'h20;
  localparam logic [15:0] TCC_MOD_RST = 16'hFFFF;
  localparam int TCC_SYNC_STAGES = 2;
  typedef enum logic [1:0] {TCC_EDGE_NONE, TCC_EDGE_RISE, TCC_EDGE_FALL, TCC_EDGE_BOTH} tcc_edge_t;
endpackage

// ### hdl/tcc_val_mem.sv
// six-word channel value store, registered read port, no reset
`timescale 1ns/100ps
module tcc_val_mem
  import tcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [TCC_NCH-1:0] wr_en,
  input wire logic [TCC_NCH*TCC_CW-1:0] wr_data,
  input wire logic [2:0] rd_addr,
  output logic [TCC_CW-1:0] rd_data,
  output logic [TCC_NCH*TCC_CW-1:0] all_data
);
  logic [TCC_CW-1:0] mem_r [TCC_NCH];
  genvar g;
  generate
    for (g = 0; g < TCC_NCH; g++) begin : g_word
      // contents deliberately kept across reset
      always_ff @(posedge clk_sys) begin
        if (wr_en[g]) begin
          mem_r[g] <= wr_data[g*TCC_CW +: TCC_CW];
        end
      end
      assign all_data[g*TCC_CW +: TCC_CW] = mem_r[g];
    end
  endgenerate
  always_ff @(posedge clk_sys) begin
    rd_data <= (rd_addr < 3'(TCC_NCH)) ? mem_r[rd_addr] : '0;
  end
endmodule

// ### hdl/tcc_top.sv
// six-channel 16-bit timer capture/compare/pwm channel logic
// Operation
// - active capture edge copies full 16-bit counter into channel value
// - two edge-select bits per channel choose capture polarity
// - captured value equals counter before pin edge plus two
// - every qualifying edge overwrites value regardless of flag state
// - capture sets event flag; flag and enable raise interrupt request
// - channel values are untouched by reset
// - compare match sets, clears or toggles pin as configured
// - compare match sets event flag, interrupt if enabled
// - unbuffered compare value takes effect immediately on write
// - even channel buffer select links pair 0/1, output on channel 0
// - inactive channel write takes control after next overflow
// - pairs 2/3 and 4/5 link the same way
// - linked odd channel capture, compare and irq off, its pin released; toggle and max bits still drive its level
// - toggle-on-overflow toggles pin at the modulo value
// - modulo 255, prescale 0 gives 256-clock period
// - value 128 with 8-bit period gives 50 percent duty
// - shared counter runs free or modulo-bounded, base for all channels
// - counter clock from seven prescaled rates or external pin
// - mode 0:1 unbuffered, 1:0 buffered; edge 1:0 clear, 1:1 set
`timescale 1ns/100ps
module tcc_top
  import tcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic external_timer_clock_pin,
  input wire logic [TCC_NCH-1:0] channel_pin_in,
  output logic [TCC_NCH-1:0] channel_pin_out,
  output logic [TCC_NCH-1:0] channel_pin_oe,
  output logic [TCC_NCH-1:0] channel_pin_released,
  output logic [TCC_NCH-1:0] channel_irq,
  output logic overflow_pulse
);
  // ---------- register decode ----------
  function automatic logic [2:0] ch_of(input logic [7:0] a, input logic [7:0] base);
    ch_of = 3'(a - base);
  endfunction
  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    in_bank = (a >= base) && (a < base + 8'(TCC_NCH));
  endfunction
  wire wr_g = reg_wr && (reg_addr == TCC_IDX_GCTRL);
  wire wr_mod = reg_wr && (reg_addr == TCC_IDX_MOD);
  wire wr_ctl = reg_wr && in_bank(reg_addr, TCC_IDX_CH_BASE);
  wire wr_val = reg_wr && in_bank(reg_addr, TCC_IDX_VAL_BASE);
  wire [2:0] ctl_ch = ch_of(reg_addr, TCC_IDX_CH_BASE);
  wire [2:0] val_ch = ch_of(reg_addr, TCC_IDX_VAL_BASE);

  logic [7:0] gctrl_r;
  logic [15:0] mod_r;
  logic [15:0] cnt_r;
  logic [7:0] ctrl_r [TCC_NCH];
  logic [TCC_NCH-1:0] flag_r;
  logic [TCC_NCH-1:0] pin_r;
  logic [2:0] sel_r;
  logic [2:0] rd_ch_r;
  logic [1:0] rd_kind_r;
  logic [15:0] rd_direct_r;
  logic [TCC_NCH*TCC_CW-1:0] vals;
  logic [TCC_CW-1:0] mem_rd;

  // ---------- prescaler and counter ----------
  logic [1:0] ext_sync_r;
  logic ext_prev_r;
  logic [6:0] pre_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ext_sync_r <= 2'h0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_sync_r <= {ext_sync_r[0], external_timer_clock_pin};
      ext_prev_r <= ext_sync_r[1];
    end
  end
  wire [2:0] ps = gctrl_r[TCC_B_PS +: 3];
  wire ext_tick = ext_sync_r[1] && !ext_prev_r;
  logic tick;
  always_comb begin
    // rate 1/2^ps of the bus clock, or the pin for the top code
    if (ps == 3'h7) begin
      tick = ext_tick;
    end else if (ps == 3'h0) begin
      tick = 1'b1;
    end else begin
      tick = (pre_r & ((7'h01 << ps) - 7'h01)) == ((7'h01 << ps) - 7'h01);
    end
  end
  wire run = !gctrl_r[TCC_B_STOP];
  // wrap at the modulo value: 255 gives a 256-step period
  wire at_mod = (cnt_r == mod_r);
  // count that the counter moves to on this tick; compares key on it
  wire [15:0] cnt_nxt = at_mod ? 16'h0000 : cnt_r + 16'h0001;
  wire ovf = run && tick && at_mod;
  assign overflow_pulse = ovf;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || wr_g && reg_wdata[TCC_B_RST]) begin
      pre_r <= 7'h00;
      cnt_r <= 16'h0000;
    end else if (run) begin
      pre_r <= pre_r + 7'h01;
      if (tick) begin
        cnt_r <= cnt_nxt;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gctrl_r <= TCC_GCTRL_RST;
      mod_r <= TCC_MOD_RST;
    end else begin
      // reset-bit self-clears; it is a command, not state
      if (wr_g) gctrl_r <= {reg_wdata[7:5], 1'b0, reg_wdata[3:0]};
      if (wr_mod) mod_r <= reg_wdata;
    end
  end

  // ---------- capture synchroniser, last two counts kept ----------
  logic [TCC_NCH-1:0] s1_r, s2_r, s3_r;
  logic [15:0] cnt_d1_r, cnt_d2_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= channel_pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
    cnt_d1_r <= cnt_r;
    cnt_d2_r <= cnt_d1_r;
  end

  // ---------- per-channel logic ----------
  logic [TCC_NCH-1:0] wr_mem;
  logic [TCC_NCH*TCC_CW-1:0] mem_wd;
  logic [TCC_NCH-1:0] cap_ev, cmp_ev, linked_odd;
  genvar g;
  generate
    for (g = 0; g < TCC_NCH; g++) begin : g_ch
      localparam int EV = g & ~1;
      wire [7:0] c = ctrl_r[g];
      wire pair_buf = ctrl_r[EV][TCC_B_MSB];
      wire odd_link = (g % 2 == 1) && pair_buf;
      wire is_out = c[TCC_B_MSB] || c[TCC_B_MSA];
      wire [1:0] els = {c[TCC_B_ELB], c[TCC_B_ELA]};
      wire rise = s2_r[g] && !s3_r[g];
      wire fall = !s2_r[g] && s3_r[g];
      // 01 rising, 10 falling, 11 either
      wire cap = !is_out && !odd_link &&
                 ((els[0] && rise) || (els[1] && fall));
      // active source: own value unbuffered, pair select when buffered
      wire [15:0] cmp_val = (g % 2 == 0 && pair_buf) ?
                            vals[(EV + 32'(sel_r[g/2]))*TCC_CW +: TCC_CW] :
                            vals[g*TCC_CW +: TCC_CW];
      // match as the count arrives: value 128 in a 256 period gives 128 high clocks
      wire cmp = is_out && !odd_link && (g % 2 == 0 || !pair_buf) &&
                 run && tick && (cnt_nxt == cmp_val);
      assign cap_ev[g] = cap;
      assign cmp_ev[g] = cmp;
      assign linked_odd[g] = odd_link;
      assign wr_mem[g] = cap || (wr_val && val_ch == 3'(g));
      // counter two edges back, plus two, as seen at the bus
      assign mem_wd[g*TCC_CW +: TCC_CW] = cap ? cnt_d2_r + 16'h0002 : reg_wdata;

      logic pin_nxt;
      always_comb begin
        pin_nxt = pin_r[g];
        if (cmp) begin
          case (els)
            2'h1: pin_nxt = !pin_r[g];
            2'h2: pin_nxt = 1'b0;
            2'h3: pin_nxt = 1'b1;
            default: pin_nxt = pin_r[g];
          endcase
        end
        // overflow toggle wins over a compare on the same count
        if (is_out && ovf && c[TCC_B_TOV]) pin_nxt = !pin_r[g];
        if (is_out && !c[TCC_B_TOV] && c[TCC_B_MAX]) pin_nxt = 1'b1;
      end
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          ctrl_r[g] <= TCC_CTRL_RST;
          flag_r[g] <= 1'b0;
          pin_r[g] <= 1'b0;
        end else begin
          if (wr_ctl && ctl_ch == 3'(g)) ctrl_r[g] <= {1'b0, reg_wdata[6:0]};
          // flag clears by writing zero; a new event wins
          if (cap || cmp) begin
            flag_r[g] <= 1'b1;
          end else if (wr_ctl && ctl_ch == 3'(g) && !reg_wdata[TCC_B_FLAG]) begin
            flag_r[g] <= 1'b0;
          end
          pin_r[g] <= pin_nxt;
        end
      end
      assign channel_irq[g] = flag_r[g] && c[TCC_B_IE] && !odd_link;
      assign channel_pin_out[g] = pin_r[g];
      assign channel_pin_oe[g] = is_out && !odd_link;
      assign channel_pin_released[g] = odd_link;
    end
  endgenerate

  // pair selects: even first, last-written set takes over at overflow
  logic [2:0] pend_r;
  generate
    for (g = 0; g < 3; g++) begin : g_pair
      wire lnk = ctrl_r[2*g][TCC_B_MSB];
      wire wr_e = wr_val && val_ch == 3'(2*g);
      wire wr_o = wr_val && val_ch == 3'(2*g+1);
      always_ff @(posedge clk_sys) begin
        if (!rst_n || !lnk) begin
          pend_r[g] <= 1'b0;
          sel_r[g] <= 1'b0;
        end else begin
          if (wr_o) pend_r[g] <= 1'b1;
          else if (wr_e) pend_r[g] <= 1'b0;
          if (ovf) sel_r[g] <= wr_o ? 1'b1 : (wr_e ? 1'b0 : pend_r[g]);
        end
      end
    end
  endgenerate

  tcc_val_mem u_mem (
    .clk_sys(clk_sys),
    .wr_en(wr_mem),
    .wr_data(mem_wd),
    .rd_addr(val_ch),
    .rd_data(mem_rd),
    .all_data(vals)
  );

  // ---------- read path ----------
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (reg_addr == TCC_IDX_GCTRL) rd_mux = {8'h00, gctrl_r};
    else if (reg_addr == TCC_IDX_MOD) rd_mux = mod_r;
    else if (reg_addr == TCC_IDX_COUNT) rd_mux = cnt_r;
    else if (reg_addr == TCC_IDX_PIN) rd_mux = {10'h000, pin_r};
    else if (in_bank(reg_addr, TCC_IDX_CH_BASE))
      rd_mux = {8'h00, flag_r[ctl_ch], ctrl_r[ctl_ch][6:0]};
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_kind_r <= 2'h0;
      rd_direct_r <= 16'h0000;
    end else begin
      rd_kind_r <= {reg_rd && in_bank(reg_addr, TCC_IDX_VAL_BASE), reg_rd};
      rd_direct_r <= rd_mux;
    end
  end
  assign reg_rdata = !rd_kind_r[0] ? 16'h0000 : (rd_kind_r[1] ? mem_rd : rd_direct_r);

  // ---------- assertions ----------
  generate
    for (g = 0; g < TCC_NCH; g++) begin : g_chk
      a_capture_value: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cap_ev[g] |=> vals[g*TCC_CW +: TCC_CW] == $past(cnt_r, 3) + 16'h0002)
        else $error("capture value wrong");
      a_event_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cap_ev[g] || cmp_ev[g]) |=> flag_r[g])
        else $error("event flag not set");
      a_sync_delay: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cap_ev[g] |-> $past(channel_pin_in[g], 2) != $past(channel_pin_in[g], 3))
        else $error("capture without pin change");
      a_odd_released: assert property (@(posedge clk_sys) disable iff (!rst_n)
        linked_odd[g] |-> !channel_pin_oe[g] && !cmp_ev[g] && !cap_ev[g])
        else $error("linked odd channel active");
    end
  endgenerate
  sequence s_odd_write(int p);
    wr_val && val_ch == 3'(2*p+1) && ctrl_r[2*p][TCC_B_MSB];
  endsequence
  // pair 4/5 is the pair that sees both hand-overs in normal use
  a_odd_pending: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_odd_write(2) |=> pend_r[2])
    else $error("odd write not held pending");
  a_buffer_switch: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ovf && ctrl_r[4][TCC_B_MSB] && pend_r[2] && !wr_val |=> sel_r[2])
    else $error("pair select did not switch");
  a_switch_at_ovf: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !ovf && ctrl_r[4][TCC_B_MSB] && $past(ctrl_r[4][TCC_B_MSB]) |=> $stable(sel_r[2]))
    else $error("select moved without overflow");
  a_counter_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ovf |=> cnt_r == 16'h0000)
    else $error("counter did not wrap");
  a_clear_action: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmp_ev[0] && ctrl_r[0][TCC_B_ELB +: 1] && !ctrl_r[0][TCC_B_ELA] && !ovf &&
    !ctrl_r[0][TCC_B_MAX] |=> !pin_r[0])
    else $error("clear on compare failed");
endmodule

// ### tb/tcc_pin_model.sv
// external signal source driving the six capture pins
`timescale 1ns/100ps
module tcc_pin_model
  import tcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [TCC_NCH-1:0] level_req,
  input wire logic [3:0] lag,
  output logic [TCC_NCH-1:0] pin_lvl
);
  int wait_cnt;
  initial begin
    pin_lvl = '0;
    wait_cnt = 0;
  end
  // lag > 0 models a slow source: the new level shows lag edges late
  always @(posedge clk_sys) begin
    if (level_req === pin_lvl) begin
      wait_cnt <= 0;
    end else if (wait_cnt >= int'(lag)) begin
      pin_lvl <= level_req;
      wait_cnt <= 0;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

// ### tb/tb_timer_capture_compare_pwm.sv
// self-checking bench for the timer capture/compare/pwm channel block
`timescale 1ns/100ps
module tb_timer_capture_compare_pwm
  import tcc_pkg::*;
;
  logic clk_sys, rst_n, reg_wr, reg_rd, ext_clk;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv, c;
  logic [5:0] lvl, pins, pout, poe, prel, irq;
  logic [3:0] lag;
  logic ovf;
  int err_count, checks_done, hi, per;
  tcc_pin_model pm (.clk_sys(clk_sys), .level_req(lvl), .lag(lag), .pin_lvl(pins));
  tcc_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_timer_clock_pin(ext_clk),
    .channel_pin_in(pins), .channel_pin_out(pout), .channel_pin_oe(poe),
    .channel_pin_released(prel), .channel_irq(irq), .overflow_pulse(ovf));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // bounded wait for a pin level, returns cycles spent
  task automatic wait_pin(input int ch, input logic v, output int n);
    n = 0;
    while (pout[ch] !== v) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > 1000) begin
        err_count++;
        complete_run();
      end
    end
  endtask
  task automatic pwm_meas(input int ch, output int h, output int p);
    int lo;
    wait_pin(ch, 1'b0, lo);
    wait_pin(ch, 1'b1, lo);
    wait_pin(ch, 1'b0, h);
    wait_pin(ch, 1'b1, lo);
    p = h + lo;
  endtask
  task automatic t_reset();
    rd(TCC_IDX_GCTRL, rv);
    chk(rv, 16'h0020);
    rd(TCC_IDX_MOD, rv);
    chk(rv, 16'hFFFF);
    rd(TCC_IDX_COUNT, rv);
    chk(rv, 16'h0000);
    rd(8'h03, rv);
    chk(rv, 16'h0000);
  endtask
  // pin edge launched in the same cycle as the counter read
  task automatic edge_and_count(input logic [5:0] v);
    @(posedge clk_sys);
    lvl <= v;
    rd(TCC_IDX_COUNT, c);
    repeat (12) @(posedge clk_sys);
  endtask
  task automatic t_capture();
    logic [15:0] first;
    wr(TCC_IDX_CH_BASE, 16'h0044);
    wr(TCC_IDX_CH_BASE + 8'h01, 16'h0008);
    wr(TCC_IDX_GCTRL, 16'h0010);
    edge_and_count(6'h03);
    first = c + 16'h0002;
    rd(TCC_IDX_VAL_BASE, rv);
    chk(rv, first);
    rd(TCC_IDX_CH_BASE + 8'h01, rv);
    chk(rv, 16'h0008);
    chk({15'h0000, irq[0]}, 16'h0001);
    chk({15'h0000, irq[1]}, 16'h0000);
    edge_and_count(6'h00);
    rd(TCC_IDX_VAL_BASE + 8'h01, rv);
    chk(rv, c + 16'h0002);
    rd(TCC_IDX_VAL_BASE, rv);
    chk(rv, first);
    lag <= 4'h3;
    edge_and_count(6'h01);
    rd(TCC_IDX_VAL_BASE, rv);
    chk(rv, c + 16'h0005);
    rd(TCC_IDX_CH_BASE, rv);
    chk(rv, 16'h00C4);
    lag <= 4'h0;
    first = c + 16'h0005;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(TCC_IDX_VAL_BASE, rv);
    chk(rv, first);
    rd(TCC_IDX_CH_BASE, rv);
    chk(rv, 16'h0000);
  endtask
  task automatic t_prescale();
    wr(TCC_IDX_GCTRL, 16'h0001);
    rd(TCC_IDX_COUNT, c);
    repeat (8) @(posedge clk_sys);
    rd(TCC_IDX_COUNT, rv);
    chk(rv - c, 16'h0005);
    wr(TCC_IDX_GCTRL, 16'h0007);
    rd(TCC_IDX_COUNT, c);
    repeat (8) begin
      repeat (4) @(posedge clk_sys);
      ext_clk <= ~ext_clk;
    end
    repeat (6) @(posedge clk_sys);
    rd(TCC_IDX_COUNT, rv);
    chk(rv - c, 16'h0004);
  endtask
  task automatic t_pwm();
    logic b;
    int n;
    wr(TCC_IDX_MOD, 16'h00FF);
    wr(TCC_IDX_VAL_BASE + 8'h02, 16'h0080);
    wr(TCC_IDX_VAL_BASE + 8'h03, 16'h0010);
    wr(TCC_IDX_VAL_BASE + 8'h05, 16'h0020);
    wr(TCC_IDX_CH_BASE + 8'h02, 16'h001A);
    wr(TCC_IDX_CH_BASE + 8'h03, 16'h0014);
    wr(TCC_IDX_CH_BASE + 8'h05, 16'h001C);
    wr(TCC_IDX_GCTRL, 16'h0010);
    pwm_meas(2, hi, per);
    chk(16'(hi), 16'h0080);
    chk(16'(per), 16'h0100);
    chk({15'h0000, poe[2]}, 16'h0001);
    rd(TCC_IDX_CH_BASE + 8'h02, rv);
    chk({15'h0000, rv[7]}, 16'h0001);
    b = pout[3];
    n = 0;
    repeat (256) begin
      @(posedge clk_sys);
      #1;
      if (ovf === 1'b1) n++;
    end
    chk(16'(n), 16'h0001);
    chk({15'h0000, pout[3]}, {15'h0000, ~b});
    chk({15'h0000, pout[5]}, 16'h0001);
    // smaller value written just after its compare
    wait_pin(2, 1'b0, n);
    wr(TCC_IDX_VAL_BASE + 8'h02, 16'h0040);
    pwm_meas(2, hi, per);
    chk(16'(hi), 16'h0040);
    // larger value written just after the overflow
    wr(TCC_IDX_VAL_BASE + 8'h02, 16'h0080);
    pwm_meas(2, hi, per);
    chk(16'(hi), 16'h0080);
    // max bit without toggle-on-wrap holds the pin high
    wait_pin(3, 1'b0, n);
    wr(TCC_IDX_CH_BASE + 8'h03, 16'h0015);
    @(posedge clk_sys);
    #1;
    chk({15'h0000, pout[3]}, 16'h0001);
  endtask
  task automatic t_buffer();
    wr(TCC_IDX_VAL_BASE + 8'h04, 16'h0040);
    wr(TCC_IDX_CH_BASE, 16'h002A);
    wr(TCC_IDX_CH_BASE + 8'h02, 16'h002A);
    wr(TCC_IDX_CH_BASE + 8'h04, 16'h002A);
    @(posedge clk_sys);
    #1;
    chk({10'h000, prel}, 16'h002A);
    chk({15'h0000, poe[5]}, 16'h0000);
    pwm_meas(4, hi, per);
    chk(16'(hi), 16'h0040);
    // odd set written just after the overflow, only the next period may use it
    wr(TCC_IDX_VAL_BASE + 8'h05, 16'h00C0);
    pwm_meas(4, hi, per);
    chk(16'(hi), 16'h00C0);
    wr(TCC_IDX_VAL_BASE + 8'h04, 16'h0020);
    pwm_meas(4, hi, per);
    chk(16'(hi), 16'h0020);
  endtask
  initial begin
    err_count = 0;
    checks_done = 0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    ext_clk = 1'b0;
    lvl = 6'h00;
    lag = 4'h0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_capture();
    t_prescale();
    t_pwm();
    t_buffer();
    complete_run();
  end
endmodule
